/* design/svd_pkg.sv */
// Package for the supply-detect reset logic: register map, field
// positions, reset values and timing counts.
// Assumes a 125 MHz system clock and an 8-bit register port.
package svd_pkg;
  // Register indices on the plain register port
  localparam logic [0:0] ADDR_CONTROL = 1'h0;
  localparam logic [0:0] ADDR_STATUS = 1'h1;
  // Control field positions
  localparam int CTL_DET_EN = 7;
  localparam int CTL_LVL_SEL = 3;
  localparam int CTL_RST_EN = 2;
  localparam int CTL_FALL_IE = 1;
  localparam int CTL_RISE_IE = 0;
  localparam logic [7:0] CTL_FIXED_ONES = 8'h70;
  // Status field positions
  localparam int STS_FALL = 1;
  localparam int STS_RISE = 0;
  localparam logic [7:0] STS_FIXED_ONES = 8'hfc;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int PRESCALE_CYCLES = 131072;
  localparam int FILTER_NS = 100;
  localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ) / 1000;
  localparam int DETECTOR_SETTLE_US = 50;
endpackage

/* design/svd_reset_logic.sv */
// Supply-detect reset and interrupt control for a supply monitor.
// Assumes analog comparators and the reset pin are asynchronous.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module svd_reset_logic
  import svd_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic cmp_below_fall,
  input wire logic cmp_above_rise,
  input wire logic cmp_below_reset_hi,
  input wire logic cmp_below_reset_lo,
  input wire logic reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic internal_reset_n,
  output logic low_voltage_reset_n,
  output logic low_voltage_detect_n,
  output logic supply_irq_request,
  output logic reset_level_select
);

  typedef enum logic [1:0] {
    SVD_RST_HOLD,
    SVD_RST_COUNT,
    SVD_RST_RUN
  } svd_rst_state_t;

  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] fall_sync;
    logic [1:0] rise_sync;
    logic [1:0] rhi_sync;
    logic [1:0] rlo_sync;
    logic pin_filt;
    logic [7:0] filt_cnt;
    svd_rst_state_t rst_state;
    logic [17:0] presc;
    logic det_en;
    logic lvl_sel;
    logic rst_en;
    logic fall_ie;
    logic rise_ie;
    logic fall_flag;
    logic rise_flag;
    logic fall_read1;
    logic rise_read1;
    logic armed;
    logic below_fall_d;
    logic [7:0] rdata;
    logic int_rst_n;
    logic lvr_n;
    logic det_n;
    logic irq;
  } svd_state_t;

  svd_state_t cur_ff;
  svd_state_t nxt_ff;

  // Counter is 18 bits wide, so PRESCALE must stay at or below 2**18
  localparam logic [7:0] FILT_LIMIT = 8'(FILTER_CYCLES);
  localparam logic [17:0] PRESC_LAST = 18'(PRESCALE - 1);

  // Flag clear: write of zero only after a read saw one
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic wr0, input logic seen1);
    flag_next = set | (cur & ~(wr0 & seen1));
  endfunction

  logic below_fall;
  logic above_rise;
  logic below_rst;
  logic fall_evt;
  logic rise_evt;
  logic lvr_hit;
  logic wr_ctl;
  logic wr_sts;
  logic rd_sts;

  // Decoded conditions shared by the next-state logic
  always_comb begin
    below_fall = cur_ff.fall_sync[1] & cur_ff.det_en;
    above_rise = cur_ff.rise_sync[1];
    // Higher level when the level select is set, else the lower level
    below_rst = cur_ff.lvl_sel ? cur_ff.rhi_sync[1]
                               : cur_ff.rlo_sync[1];
    lvr_hit = cur_ff.det_en & cur_ff.rst_en & below_rst;
    fall_evt = below_fall & ~cur_ff.below_fall_d;
    rise_evt = cur_ff.armed & above_rise & cur_ff.det_en;
    wr_ctl = reg_wr & (reg_addr == ADDR_CONTROL);
    wr_sts = reg_wr & (reg_addr == ADDR_STATUS);
    rd_sts = reg_rd & (reg_addr == ADDR_STATUS);
  end

  // Next-state logic for the whole block
  always_comb begin
    nxt_ff = cur_ff;
    // Two-stage synchronisers; first stage feeds only the second
    nxt_ff.pin_sync = {cur_ff.pin_sync[0], reset_pin_n};
    nxt_ff.fall_sync = {cur_ff.fall_sync[0], cmp_below_fall};
    nxt_ff.rise_sync = {cur_ff.rise_sync[0], cmp_above_rise};
    nxt_ff.rhi_sync = {cur_ff.rhi_sync[0], cmp_below_reset_hi};
    nxt_ff.rlo_sync = {cur_ff.rlo_sync[0], cmp_below_reset_lo};
    // Pin must hold a new level this long before it is believed
    if (cur_ff.pin_sync[1] == cur_ff.pin_filt) begin
      nxt_ff.filt_cnt = 8'h00;
    end else if (cur_ff.filt_cnt >= FILT_LIMIT) begin
      nxt_ff.pin_filt = cur_ff.pin_sync[1];
      nxt_ff.filt_cnt = 8'h00;
    end else begin
      nxt_ff.filt_cnt = cur_ff.filt_cnt + 8'h01;
    end
    // Reset sequencer around the prescaler
    case (cur_ff.rst_state)
      SVD_RST_HOLD: begin
        nxt_ff.presc = 18'h00000;
        if (cur_ff.pin_filt && !lvr_hit) begin
          nxt_ff.rst_state = SVD_RST_COUNT;
        end
      end
      SVD_RST_COUNT: begin
        nxt_ff.presc = cur_ff.presc + 18'h00001;
        if (cur_ff.presc == PRESC_LAST) begin
          nxt_ff.rst_state = SVD_RST_RUN;
          nxt_ff.int_rst_n = 1'b1;
        end
      end
      SVD_RST_RUN: begin
        nxt_ff.int_rst_n = 1'b1;
      end
      default: begin
        nxt_ff.rst_state = SVD_RST_HOLD;
      end
    endcase
    nxt_ff.lvr_n = ~lvr_hit;
    // Pin reset and low-voltage reset override the sequencer
    if (!cur_ff.pin_filt || lvr_hit) begin
      nxt_ff.rst_state = SVD_RST_HOLD;
      nxt_ff.presc = 18'h00000;
      nxt_ff.int_rst_n = 1'b0;
    end
    // Control register; the low-voltage reset path keeps sticky fields
    if (!cur_ff.pin_filt || watchdog_reset) begin
      nxt_ff.det_en = 1'b0;
      nxt_ff.lvl_sel = 1'b0;
      nxt_ff.rst_en = 1'b0;
      nxt_ff.fall_ie = 1'b0;
      nxt_ff.rise_ie = 1'b0;
    end else if (lvr_hit) begin
      nxt_ff.fall_ie = 1'b0;
      nxt_ff.rise_ie = 1'b0;
    end else if (wr_ctl) begin
      nxt_ff.det_en = reg_wdata[CTL_DET_EN];
      nxt_ff.lvl_sel = reg_wdata[CTL_LVL_SEL];
      nxt_ff.rst_en = reg_wdata[CTL_RST_EN];
      nxt_ff.fall_ie = reg_wdata[CTL_FALL_IE];
      nxt_ff.rise_ie = reg_wdata[CTL_RISE_IE];
    end
    // Rise arming: any fall event arms, cancelled by reset drop or detector off
    if (lvr_hit || below_rst || !cur_ff.det_en) begin
      nxt_ff.armed = 1'b0;
    end else if (fall_evt) begin
      nxt_ff.armed = 1'b1;
    end else if (rise_evt) begin
      nxt_ff.armed = 1'b0;
    end
    nxt_ff.below_fall_d = below_fall;
    // Detect signal low on fall, high again on rise
    if (fall_evt) begin
      nxt_ff.det_n = 1'b0;
    end else if (rise_evt) begin
      nxt_ff.det_n = 1'b1;
    end
    // Status flags; a set in the clearing cycle wins
    nxt_ff.fall_flag = flag_next(cur_ff.fall_flag, fall_evt,
      wr_sts & ~reg_wdata[STS_FALL], cur_ff.fall_read1);
    nxt_ff.rise_flag = flag_next(cur_ff.rise_flag,
      rise_evt & cur_ff.rise_ie,
      wr_sts & ~reg_wdata[STS_RISE], cur_ff.rise_read1);
    if (rd_sts) begin
      nxt_ff.fall_read1 = cur_ff.fall_flag;
      nxt_ff.rise_read1 = cur_ff.rise_flag;
    end else if (wr_sts) begin
      nxt_ff.fall_read1 = 1'b0;
      nxt_ff.rise_read1 = 1'b0;
    end
    // Either reset wipes the flags and parks the detect signal high
    if (!cur_ff.pin_filt || lvr_hit) begin
      nxt_ff.fall_flag = 1'b0;
      nxt_ff.rise_flag = 1'b0;
      nxt_ff.det_n = 1'b1;
    end
    // Interrupt request pulse in the flag-setting cycle
    nxt_ff.irq = (fall_evt & cur_ff.fall_ie)
               | (rise_evt & cur_ff.rise_ie);
    // Read data
    nxt_ff.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ADDR_STATUS) begin
        nxt_ff.rdata = STS_FIXED_ONES
          | {6'h00, cur_ff.fall_flag, cur_ff.rise_flag};
      end else begin
        nxt_ff.rdata = CTL_FIXED_ONES | {cur_ff.det_en, 3'h0,
          cur_ff.lvl_sel, cur_ff.rst_en, cur_ff.fall_ie,
          cur_ff.rise_ie};
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
      cur_ff.det_n <= 1'b1;
      cur_ff.lvr_n <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign internal_reset_n = cur_ff.int_rst_n;
  assign low_voltage_reset_n = cur_ff.lvr_n;
  assign low_voltage_detect_n = cur_ff.det_n;
  assign supply_irq_request = cur_ff.irq;
  assign reset_level_select = cur_ff.lvl_sel;

  // Checks on the register view
  a_status_ones: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $past(rd_sts) |-> reg_rdata[7:2] == 6'h3f)
    else $error("status upper bits not one");
  a_ctl_ones: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $past(reg_rd) && ($past(reg_addr) == ADDR_CONTROL)
    |-> reg_rdata[6:4] == 3'h7)
    else $error("control fixed bits not one");
  a_ctl_reset: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    !cur_ff.pin_filt || watchdog_reset
    |=> !cur_ff.det_en && !cur_ff.lvl_sel && !cur_ff.rst_en)
    else $error("control not cleared by chip reset");

  // Checks on the status flags and the request
  a_fall_sets: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    fall_evt && cur_ff.pin_filt && !lvr_hit |=> cur_ff.fall_flag)
    else $error("fall flag not set");
  a_clear_needs_read: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    cur_ff.fall_flag && !cur_ff.fall_read1 && cur_ff.pin_filt
    && !lvr_hit |=> cur_ff.fall_flag)
    else $error("flag cleared without read");
  a_flag_cleared: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    cur_ff.fall_flag && cur_ff.fall_read1 && wr_sts && !reg_wdata[STS_FALL]
    && !fall_evt |=> !cur_ff.fall_flag)
    else $error("flag not cleared after read");
  a_rise_needs_en: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $rose(cur_ff.rise_flag) |-> $past(cur_ff.rise_ie))
    else $error("rise flag without enable");
  a_rise_sets: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    rise_evt && !fall_evt && cur_ff.rise_ie && cur_ff.pin_filt && !lvr_hit
    |=> cur_ff.rise_flag && supply_irq_request && low_voltage_detect_n)
    else $error("rise flag or irq missing");
  a_irq_fall: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    fall_evt && cur_ff.fall_ie && cur_ff.pin_filt && !lvr_hit
    |=> supply_irq_request && !low_voltage_detect_n)
    else $error("fall irq missing");

  // Checks on the reset path
  a_pin_holds: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    !cur_ff.pin_filt |=> !internal_reset_n)
    else $error("reset released while pin low");
  a_hold_presc: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    !cur_ff.pin_filt
    |=> cur_ff.rst_state == SVD_RST_HOLD && cur_ff.presc == 18'h00000)
    else $error("prescaler not held while pin low");
  a_count_start: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    cur_ff.rst_state == SVD_RST_HOLD && cur_ff.pin_filt && !lvr_hit
    |=> cur_ff.rst_state == SVD_RST_COUNT)
    else $error("prescaler did not start");
  a_presc_release: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $rose(internal_reset_n) |-> $past(cur_ff.presc) == PRESC_LAST)
    else $error("release before overflow");
  a_filter_short: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $changed(cur_ff.pin_filt) |-> $past(cur_ff.filt_cnt) == FILT_LIMIT)
    else $error("pin change not filtered");
  a_lvr_drive: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    lvr_hit |=> !low_voltage_reset_n && !internal_reset_n)
    else $error("low voltage reset missing");
  a_lvr_exit: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    $rose(low_voltage_reset_n) |-> !internal_reset_n)
    else $error("internal reset left before recount");
  a_lvr_keeps: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    lvr_hit && cur_ff.pin_filt && !watchdog_reset
    |=> $stable(cur_ff.det_en) && $stable(cur_ff.rst_en)
    && $stable(cur_ff.lvl_sel))
    else $error("lvr cleared sticky bits");
  a_lvr_irq_off: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    lvr_hit |=> !cur_ff.fall_ie && !cur_ff.rise_ie)
    else $error("lvr kept interrupt enables");

  // Main scenarios
  c_lvr: cover property (@(posedge sys_clk) $fell(low_voltage_reset_n));
  c_release: cover property (@(posedge sys_clk) $rose(internal_reset_n));
  c_rise: cover property (@(posedge sys_clk) $rose(cur_ff.rise_flag));
  c_fall_irq: cover property (@(posedge sys_clk) fall_evt && cur_ff.fall_ie);
  c_high_level: cover property (@(posedge sys_clk) lvr_hit && cur_ff.lvl_sel);

endmodule // svd_reset_logic

/* test/svd_supply_model.sv */
// Comparator model standing in for the analog supply detectors.
// Assumes the bench changes the level code just after a clock edge.
`timescale 1ns/10ps
module svd_supply_model (
  input wire logic [1:0] level,
  output logic below_fall,
  output logic above_rise,
  output logic below_rst_hi,
  output logic below_rst_lo
);
  // Code 0 healthy, 1 under fall level, 2 under both reset levels,
  // 3 between the two reset levels, so the level select matters
  assign above_rise = (level == 2'h0);
  assign below_fall = (level != 2'h0);
  assign below_rst_hi = level[1];
  assign below_rst_lo = (level == 2'h2);
endmodule // svd_supply_model

/* test/svd_reset_logic_tb.sv */
// Self-checking bench for the supply-detect reset logic.
// Assumes 125 MHz clock; prescaler shortened to keep the run brief.
`timescale 1ns/10ps
module svd_reset_logic_tb;
  import svd_pkg::*;
  localparam int PRE = 16;
  localparam int SETTLE = DETECTOR_SETTLE_US * CLK_MHZ;
  logic sys_clk, resetn, pin_n, wdog, addr, wr, rd;
  logic [7:0] wdata, rdata;
  logic irst_n, lvr_n, det_n, irq, sel, c_fall, c_rise, c_hi, c_lo;
  logic [1:0] lvl;
  int failures, num_checks;
  svd_supply_model svd_supply_model_inst (.level(lvl),
    .below_fall(c_fall), .above_rise(c_rise),
    .below_rst_hi(c_hi), .below_rst_lo(c_lo));
  svd_reset_logic #(.PRESCALE(PRE)) svd_reset_logic_inst (
    .sys_clk(sys_clk), .resetn(resetn), .reset_pin_n(pin_n),
    .watchdog_reset(wdog), .cmp_below_fall(c_fall),
    .cmp_above_rise(c_rise), .cmp_below_reset_hi(c_hi),
    .cmp_below_reset_lo(c_lo), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .internal_reset_n(irst_n), .low_voltage_reset_n(lvr_n),
    .low_voltage_detect_n(det_n), .supply_irq_request(irq),
    .reset_level_select(sel));
  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle strobes, as the register port expects
  task automatic wr_reg(logic a, logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(string what, logic a, logic [7:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(what, rdata, exp);
  endtask
  // The request is a single-cycle pulse, so watch every cycle
  task automatic wait_irq(output logic got);
    got = 1'b0;
    repeat (12) begin
      @(posedge sys_clk);
      #1 if (irq === 1'b1) got = 1'b1;
    end
  endtask
  task automatic rel_chk(string what);
    int n;
    n = 0;
    while (irst_n !== 1'b1 && n < PRE + 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk(what, 8'(n >= PRE && n <= PRE + 30), 8'h1);
  endtask
  task automatic set_lvl(logic [1:0] v);
    @(posedge sys_clk);
    lvl <= v;
  endtask
  // Detector on, settle, clear flags, then the chosen enables
  task automatic enable(logic [7:0] ctl);
    wr_reg(1'b0, 8'h80);
    repeat (SETTLE) @(posedge sys_clk);
    wr_reg(1'b1, 8'h00);
    wr_reg(1'b0, ctl);
  endtask
  task automatic t_reset();
    rel_chk("por_release");
    rd_chk("ctl_init", 1'b0, 8'h70);
    rd_chk("sts_init", 1'b1, 8'hfc);
    wr_reg(1'b1, 8'hff);
    rd_chk("sts_fixed", 1'b1, 8'hfc);
    $display("reset test done");
  endtask
  task automatic t_irq();
    logic got;
    enable(8'h83);
    set_lvl(2'h1);
    wait_irq(got);
    chk("fall_irq", 8'(got), 8'h1);
    chk("det_low", 8'(det_n), 8'h0);
    wr_reg(1'b1, 8'h00);
    rd_chk("fall_kept", 1'b1, 8'hfe);
    wr_reg(1'b1, 8'h00);
    rd_chk("fall_clr", 1'b1, 8'hfc);
    set_lvl(2'h0);
    wait_irq(got);
    chk("rise_irq", 8'(got), 8'h1);
    chk("det_high", 8'(det_n), 8'h1);
    rd_chk("rise_flag", 1'b1, 8'hfd);
    wr_reg(1'b0, 8'h80);
    wr_reg(1'b0, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic t_lvr();
    enable(8'h84);
    set_lvl(2'h3);
    repeat (8) @(posedge sys_clk);
    #1 chk("lvr_lo_sel", 8'(lvr_n), 8'h1);
    rd_chk("sts_mid", 1'b1, 8'hfe);
    set_lvl(2'h2);
    repeat (8) @(posedge sys_clk);
    #1 chk("lvr_low", 8'(lvr_n), 8'h0);
    chk("lvr_hold", 8'(irst_n), 8'h0);
    set_lvl(2'h0);
    rel_chk("lvr_release");
    rd_chk("ctl_kept", 1'b0, 8'hf4);
    rd_chk("sts_lvr", 1'b1, 8'hfc);
    wr_reg(1'b0, 8'h8c);
    set_lvl(2'h3);
    repeat (8) @(posedge sys_clk);
    #1 chk("lvr_hi_low", 8'(lvr_n), 8'h0);
    set_lvl(2'h0);
    rel_chk("lvr_hi_release");
    rd_chk("ctl_hi_kept", 1'b0, 8'hfc);
    wr_reg(1'b0, 8'h80);
    wr_reg(1'b0, 8'h00);
    $display("low voltage reset test done");
  endtask
  task automatic t_pin();
    @(posedge sys_clk);
    pin_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    pin_n <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 chk("glitch", 8'(irst_n), 8'h1);
    @(posedge sys_clk);
    pin_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    #1 chk("pin_hold", 8'(irst_n), 8'h0);
    @(posedge sys_clk);
    pin_n <= 1'b1;
    rel_chk("pin_release");
    $display("reset pin test done");
  endtask
  task automatic t_wdog();
    wr_reg(1'b0, 8'h88);
    #1 chk("sel_set", 8'(sel), 8'h1);
    @(posedge sys_clk);
    wdog <= 1'b1;
    @(posedge sys_clk);
    wdog <= 1'b0;
    rd_chk("ctl_wdog", 1'b0, 8'h70);
    $display("watchdog test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard, about two and a half times the expected run
  initial begin
    #250000;
    failures++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0;
    pin_n = 1'b1;
    wdog = 1'b0;
    addr = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    lvl = 2'h0;
    failures = 0;
    num_checks = 0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_irq();
    t_lvr();
    t_pin();
    t_wdog();
    report_and_stop();
  end
endmodule // svd_reset_logic_tb
